// ===== pce_port_c_ioc.sv
// Port C edge-change detector with Wishbone register slave
//
// Design decisions made here: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/100ps
module pce_port_c_ioc #(
    parameter bit WIDE_PKG = 1'b1        // 1 = all eight pins present
) (
    input  wire logic        clk_i,      // System clock, 100 MHz
    input  wire logic        rst_i,      // Synchronous reset, high
    input  wire logic [7:0]  port_c_pin_i, // Port C pins, asynchronous
    input  wire logic        cyc_i,      // Wishbone cycle
    input  wire logic        stb_i,      // Wishbone strobe
    input  wire logic        we_i,       // Wishbone write enable
    input  wire logic [4:0]  adr_i,      // Wishbone byte address
    input  wire logic [3:0]  sel_i,      // Wishbone byte selects
    input  wire logic [31:0] dat_i,      // Wishbone write data
    output logic      [31:0] dat_o,      // Wishbone read data
    output logic             ack_o,      // Wishbone acknowledge
    output logic             change_summary_flag_o, // OR of all change flags
    output logic             wake_o,     // Wake request out of sleep
    output logic             irq_o       // Level interrupt
);
    localparam logic [7:0] IMPL = WIDE_PKG ? pce_pkg::MASK_WIDE : pce_pkg::MASK_NARROW;

    pce_edge_if edges ();

    pce_edge_det #(
        .W (pce_pkg::PINS)
    ) u_det (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .pin_i  (port_c_pin_i),
        .edge_o (edges.src)
    );

    logic [7:0]  rise_en_q;
    logic [7:0]  fall_en_q;
    logic [7:0]  flags_q;
    logic [7:0]  flags_d;
    logic [7:0]  istat_q;
    logic [7:0]  istat_d;
    logic [7:0]  imask_q;
    logic        ie_q;
    logic        ack_q;
    logic [31:0] rdat_q;

    // Bus decode; a write lands on the edge where the master sees ack
    wire         req     = cyc_i & stb_i;
    wire         wr_lane = req & we_i & ack_q & sel_i[0];
    wire         hit_rise  = adr_i == {1'b0, pce_pkg::ADR_RISE};
    wire         hit_fall  = adr_i == {1'b0, pce_pkg::ADR_FALL};
    wire         hit_flags = adr_i == {1'b0, pce_pkg::ADR_FLAGS};
    wire         hit_ctrl  = adr_i == {1'b0, pce_pkg::ADR_CTRL};
    wire         hit_istat = adr_i == pce_pkg::ADR_ISTAT;
    wire         hit_imask = adr_i == pce_pkg::ADR_IMASK;
    wire  [7:0]  wbyte   = dat_i[7:0];

    // Per-pin set requests from enabled edges only
    wire  [7:0]  rise_set = edges.rise & rise_en_q & IMPL;
    wire  [7:0]  fall_set = edges.fall & fall_en_q & IMPL;
    wire  [7:0]  set_vec  = rise_set | fall_set;
    wire         wr_flags = wr_lane & hit_flags;

    // Set wins over any written value, so a clearing write never loses an edge
    assign flags_d = ((wr_flags ? wbyte : flags_q) | set_vec) & IMPL;
    // Sticky status records each edge that sets a flag; written ones clear it
    assign istat_d = ((wr_lane & hit_istat) ? (istat_q & ~wbyte) : istat_q) | set_vec;

    wire         summary = |flags_q;
    wire  [31:0] rd_mux  =
        hit_rise  ? {24'h00_0000, rise_en_q} :
        hit_fall  ? {24'h00_0000, fall_en_q} :
        hit_flags ? {24'h00_0000, flags_q}   :
        hit_ctrl  ? {30'h0000_0000, summary, ie_q} :
        hit_istat ? {24'h00_0000, istat_q}   :
        hit_imask ? {24'h00_0000, imask_q}   : 32'h0000_0000;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q  <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else begin
            ack_q  <= req & ~ack_q;
            rdat_q <= rd_mux;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rise_en_q <= pce_pkg::RST_BYTE;
            fall_en_q <= pce_pkg::RST_BYTE;
            flags_q   <= pce_pkg::RST_BYTE;
            istat_q   <= pce_pkg::RST_BYTE;
            imask_q   <= pce_pkg::RST_BYTE;
            ie_q      <= 1'b0;
        end else begin
            flags_q <= flags_d;
            istat_q <= istat_d & IMPL;
            if (wr_lane && hit_rise) begin
                rise_en_q <= wbyte & IMPL;
            end
            if (wr_lane && hit_fall) begin
                fall_en_q <= wbyte & IMPL;
            end
            if (wr_lane && hit_imask) begin
                imask_q <= wbyte & IMPL;
            end
            if (wr_lane && hit_ctrl) begin
                ie_q <= wbyte[pce_pkg::CTRL_IE_BIT];
            end
        end
    end

    assign ack_o                 = ack_q;
    assign dat_o                 = rdat_q;
    assign change_summary_flag_o = summary;
    // Wake follows the flag register, so the flag is already set when the core resumes
    assign wake_o                = ie_q & summary;
    assign irq_o                 = ie_q & (|(istat_q & imask_q));

    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence flag_write_s;
        wr_flags;
    endsequence
    sequence edge_during_write_s;
        flag_write_s ##0 (|set_vec);
    endsequence

    rise_sets_a: assert property (
        (|rise_set) |=> ((flags_q & $past(rise_set)) == $past(rise_set)))
        else $error("enabled rising edge did not set its flag");
    fall_sets_a: assert property (
        (|fall_set) |=> ((flags_q & $past(fall_set)) == $past(fall_set)))
        else $error("enabled falling edge did not set its flag");
    no_stray_set_a: assert property (
        ((flags_q & ~$past(flags_q) & ~$past(set_vec)
          & ~($past(wr_flags) ? $past(wbyte) : 8'h00)) == 8'h00))
        else $error("flag set without an enabled edge");
    zero_clears_a: assert property (
        (flag_write_s and (set_vec == 8'h00))
        |=> (flags_q == ($past(wbyte) & IMPL)))
        else $error("flag write did not store written value");
    unimpl_zero_a: assert property (
        WIDE_PKG || (((rise_en_q | fall_en_q | flags_q) & ~pce_pkg::MASK_NARROW) == 8'h00))
        else $error("absent upper bits not zero");
    summary_or_a: assert property (
        (change_summary_flag_o == (flags_q != 8'h00)) && (!irq_o || ie_q))
        else $error("summary flag not OR of flags");
    set_wins_a: assert property (
        edge_during_write_s |=> ((flags_q & $past(set_vec)) == $past(set_vec)))
        else $error("edge lost during clearing write");
    wake_edge_a: assert property (
        (ie_q && (|set_vec)) |=> (wake_o && (flags_q != 8'h00)))
        else $error("enabled edge did not wake with flag set");
    ack_pulse_a: assert property (
        (req && !ack_q) |=> ack_o ##1 !ack_o)
        else $error("ack not a single cycle after request");

    // Bus steps: a fresh request, then the acked cycle in which it lands
    sequence read_req_s;
        req && !we_i && !ack_q;
    endsequence
    sequence flags_read_s;
        read_req_s ##0 hit_flags;
    endsequence

    flags_read_a: assert property (
        flags_read_s |=> (dat_o[7:0] == $past(flags_q)))
        else $error("flag read returned wrong value");
    read_upper_a: assert property (
        ack_o |-> (dat_o[31:8] == 24'h00_0000))
        else $error("read data upper bits not zero");
    ack_idle_a: assert property (
        (!req) |=> !ack_o)
        else $error("ack without a request");
    rise_en_write_a: assert property (
        (wr_lane && hit_rise) |=> (rise_en_q == ($past(wbyte) & IMPL)))
        else $error("rise enable write not stored");
    fall_en_write_a: assert property (
        (wr_lane && hit_fall) |=> (fall_en_q == ($past(wbyte) & IMPL)))
        else $error("fall enable write not stored");
    mask_write_a: assert property (
        (wr_lane && hit_imask) |=> (imask_q == ($past(wbyte) & IMPL)))
        else $error("mask write not stored");
    ie_write_a: assert property (
        (wr_lane && hit_ctrl) |=> (ie_q == $past(wbyte[0])))
        else $error("interrupt enable write not stored");
    // Enable, mask and interrupt-enable registers may only move on the acked cycle, never on the request cycle
    no_early_write_a: assert property (
        (!ack_q) |=> ($stable(rise_en_q) && $stable(fall_en_q)
                      && $stable(imask_q) && $stable(ie_q)))
        else $error("register changed without an acked write");
    istat_set_a: assert property (
        (|set_vec) |=> ((istat_q & $past(set_vec)) == $past(set_vec)))
        else $error("status bit not set by enabled edge");
    istat_clear_a: assert property (
        (wr_lane && hit_istat && (set_vec == 8'h00))
        |=> (istat_q == ($past(istat_q) & ~$past(wbyte))))
        else $error("status write-one-clear wrong");
    flags_hold_a: assert property (
        (!wr_flags && (set_vec == 8'h00)) |=> $stable(flags_q))
        else $error("flags changed with no edge or write");
    ie_gate_a: assert property (
        (!ie_q) |-> (!irq_o && !wake_o))
        else $error("wake or interrupt without enable");
    narrow_stat_a: assert property (
        WIDE_PKG || (((istat_q | imask_q) & ~pce_pkg::MASK_NARROW) == 8'h00))
        else $error("absent status or mask bits not zero");
endmodule

// ===== pce_pkg.sv
// Constants for the port C edge-change detector
// What this block does
// - Enabled rising edge on a pin sets that pin's change flag; disabled ones ignored.
// - Enabled falling edge on a pin sets that pin's change flag; disabled ones ignored.
// - Flags set by enabled edges or by writing one; both edge enables may be active together.
// - Hardware sets flags, software reads them and clears by writing zero.
// - On small packages upper two enable and flag bits are absent, read zero.
// - Summary flag is OR of all change flags; interrupt raised when enabled, from sticky status bits whose mask bits are set.
// - Edge arriving during a clearing write leaves its flag set afterwards.
// - Enabled edge wakes device when interrupt enable set; flag updated first.
package pce_pkg;
    localparam int          PINS        = 8;
    localparam logic [7:0]  MASK_WIDE   = 8'hFF;
    localparam logic [7:0]  MASK_NARROW = 8'h3F;
    localparam logic [7:0]  RST_BYTE    = 8'h00;
    // Byte addresses of the words on the bus
    localparam logic [3:0]  ADR_RISE    = 4'h0;
    localparam logic [3:0]  ADR_FALL    = 4'h4;
    localparam logic [3:0]  ADR_FLAGS   = 4'h8;
    localparam logic [3:0]  ADR_CTRL    = 4'hC;
    // Extra words above 16 bytes use bit 4 of the address
    localparam logic [4:0]  ADR_ISTAT   = 5'h10;
    localparam logic [4:0]  ADR_IMASK   = 5'h14;
    // Control word fields
    localparam int          CTRL_IE_BIT  = 0;
    localparam int          CTRL_SUM_BIT = 1;
endpackage

// ===== pce_edge_if.sv
// Interface carrying per-pin edge pulses from the detector to the register logic
`timescale 1ns/100ps
interface pce_edge_if;
    logic [7:0] rise;
    logic [7:0] fall;
    modport src (output rise, output fall);
    modport snk (input rise, input fall);
endinterface

// ===== pce_edge_det.sv
// Pin synchroniser and single-cycle edge detector
`timescale 1ns/100ps
module pce_edge_det #(
    parameter int W = 8
) (
    input  wire logic         clk_i,   // System clock
    input  wire logic         rst_i,   // Synchronous reset, high
    input  wire logic [W-1:0] pin_i,   // Asynchronous port pins
    pce_edge_if.src           edge_o   // Edge pulses out
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;
    logic [W-1:0] prev_q;
    logic [2:0]   arm_q;
    logic         armed_q;

    // Pulses are held off until a real pin sample has reached prev_q, three
    // edges after reset, so a pin already high at reset gives no false edge.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_q  <= '0;
            sync_q  <= '0;
            prev_q  <= '0;
            arm_q   <= 3'h0;
        end else begin
            meta_q  <= pin_i;
            sync_q  <= meta_q;
            prev_q  <= sync_q;
            arm_q   <= {arm_q[1:0], 1'b1};
        end
    end

    assign armed_q = arm_q[2];

    assign edge_o.rise = armed_q ? (sync_q & ~prev_q) : '0;
    assign edge_o.fall = armed_q ? (~sync_q & prev_q) : '0;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    rise_one_shot_a: assert property (
        (|edge_o.rise) |=> ((edge_o.rise & $past(edge_o.rise)) == '0))
        else $error("rise pulse lasted more than one cycle");
    edge_delay_a: assert property (
        (armed_q && sync_q != prev_q) |-> ((edge_o.rise | edge_o.fall) == (sync_q ^ prev_q)))
        else $error("sample change did not give edge pulse");
endmodule

// ===== pce_pin_model.sv
// Behavioural model of the external port C pins
`timescale 1ns/100ps
module pce_pin_model (
    input  wire logic       clk_i,  // System clock
    input  wire logic [7:0] lvl_i,  // Requested pin levels
    input  wire logic       slow_i, // Add one cycle of lag
    output logic      [7:0] pin_o   // Pin levels
);
    logic [7:0] lag_q;
    initial pin_o = 8'h00;
    // Levels change only on clock edges, so no pulse is shorter than a cycle
    always @(posedge clk_i) begin
        lag_q <= lvl_i;
        pin_o <= slow_i ? lag_q : lvl_i;
    end
endmodule

// ===== test_port_c_edge_change_detect.sv
// Self-checking bench for the port C edge-change detector
`timescale 1ns/100ps
module test_port_c_edge_change_detect;
    logic        clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, slow = 0;
    logic [4:0]  adr = 0;
    logic [4:0]  ad [6];
    logic [31:0] wdat = 0;
    logic [31:0] rd_w, rd_n;
    logic [7:0]  lvl = 0, pin, r, f, q, fl, st;
    logic        ack, sum, wake, irq;
    logic [17:0] notes [$];
    logic [17:0] nt;
    int          err_total = 0, check_count = 0;

    always #5 clk = ~clk;

    pce_pin_model u_pins (.clk_i(clk), .lvl_i(lvl), .slow_i(slow), .pin_o(pin));
    pce_port_c_ioc u_dut (.clk_i(clk), .rst_i(rst), .port_c_pin_i(pin), .cyc_i(cyc),
        .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'h1), .dat_i(wdat), .dat_o(rd_w),
        .ack_o(ack), .change_summary_flag_o(sum), .wake_o(wake), .irq_o(irq));
    // Small package copy on the same bus and pins
    pce_port_c_ioc #(.WIDE_PKG(1'b0)) u_narrow (.clk_i(clk), .rst_i(rst),
        .port_c_pin_i(pin), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
        .sel_i(4'h1), .dat_i(wdat), .dat_o(rd_n), .ack_o(), .change_summary_flag_o(),
        .wake_o(), .irq_o());

    task automatic stop_test();
        if (err_total == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask

    // Note layout: read, narrow check, narrow value, wide value
    task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d,
                       input logic [7:0] e, input logic [7:0] ne, input logic nc);
        int n;
        n = 0;
        notes.push_back({!w, nc, ne, e});
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= a;
        wdat <= {24'h00_0000, d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1) begin
            err_total++;
            stop_test();
        end
        cyc <= 0;
        stb <= 0;
        @(posedge clk);
    endtask

    always @(posedge clk) begin
        if (ack === 1'b1) begin
            nt = notes.pop_front();
            if (nt[17]) begin
                chk(rd_w[7:0], nt[7:0]);
                if (nt[16]) chk(rd_n[7:0], nt[15:8]);
            end
        end
    end

    initial begin
        void'($urandom(34));
        ad = '{{1'b0, pce_pkg::ADR_RISE}, {1'b0, pce_pkg::ADR_FALL},
               {1'b0, pce_pkg::ADR_FLAGS}, {1'b0, pce_pkg::ADR_CTRL},
               pce_pkg::ADR_ISTAT, pce_pkg::ADR_IMASK};
        repeat (3) @(posedge clk);
        rst <= 0;
        @(posedge clk);
        for (int i = 0; i < 6; i++) bus(0, ad[i], 0, 0, 0, 1);
        bus(1, ad[3], 8'h01, 0, 0, 0);
        bus(1, ad[5], 8'hff, 0, 0, 0);
        bus(0, ad[5], 0, 8'hff, 8'h3f, 1);
        st = 0;
        for (int k = 0; k < 6; k++) begin
            r = 8'($urandom);
            f = 8'($urandom);
            q = 8'($urandom);
            slow <= 1'($urandom);
            bus(1, ad[0], r, 0, 0, 0);
            bus(1, ad[1], f, 0, 0, 0);
            bus(0, ad[1], 0, f, f & 8'h3f, 1);
            bus(1, ad[2], 8'h00, 0, 0, 0);
            fl = (~lvl & q & r) | (lvl & ~q & f);
            st = st | fl;
            lvl <= q;
            repeat (6) @(posedge clk);
            chk(8'(sum), 8'(|fl));
            chk(8'(wake), 8'(|fl));
            chk(8'(irq), 8'(|st));
            bus(0, ad[2], 0, fl, fl & 8'h3f, 1);
        end
        bus(0, ad[4], 0, st, st & 8'h3f, 1);
        bus(1, ad[5], 8'h00, 0, 0, 0);
        chk(8'(irq), 8'h00);
        bus(1, ad[4], 8'hff, 0, 0, 0);
        bus(1, ad[2], 8'h00, 0, 0, 0);
        bus(0, ad[3], 0, 8'h01, 8'h01, 1);
        bus(0, 5'h18, 0, 0, 0, 1);
        bus(1, ad[2], 8'h81, 0, 0, 0);
        bus(0, ad[2], 0, 8'h81, 8'h01, 1);
        chk(8'(sum), 8'h01);
        stop_test();
    end
endmodule
